// File: rtl/pefo_defs.vh
// Register map, field positions and reset values of the port E/F/G override
`ifndef PEFO_DEFS_VH
`define PEFO_DEFS_VH

// Register byte offsets
`define PEFO_CTRL_OFS 8'h00
`define PEFO_PORTE_OFS 8'h04
`define PEFO_DIRE_OFS 8'h08
`define PEFO_PINE_OFS 8'h0c
`define PEFO_PORTF_OFS 8'h10
`define PEFO_DIRF_OFS 8'h14
`define PEFO_PINF_OFS 8'h18
`define PEFO_PORTG_OFS 8'h1c
`define PEFO_DIRG_OFS 8'h20
`define PEFO_PING_OFS 8'h24
`define PEFO_OVRD_OFS 8'h28

// Control register fields
`define PEFO_CTRL_NOPULL_BIT 0
`define PEFO_CTRL_LEGACY_BIT 1

// Reset values
`define PEFO_CTRL_RST 2'h0
`define PEFO_PORT8_RST 8'h00
`define PEFO_PORT5_RST 5'h00

// Pin index bases in the flat pin vector
`define PEFO_E_BASE 0
`define PEFO_F_BASE 8
`define PEFO_G_BASE 16
`define PEFO_NPINS 21

// Bus response codes
`define PEFO_RESP_OKAY 2'h0
`define PEFO_RESP_SLVERR 2'h2

`endif

// File: rtl/pefo_pin_cell.v
// One port pin: merges port registers with peripheral overrides
`timescale 1ns/1ps
`default_nettype none

module pefo_pin_cell (
  // Port register bits
  input wire port_bit,
  input wire dir_bit,
  input wire global_pullup_disable,
  // Peripheral overrides
  input wire pullup_override_enable,
  input wire pullup_override_value,
  input wire direction_override_enable,
  input wire direction_override_value,
  input wire port_value_override_enable,
  input wire port_value_override_value,
  input wire input_enable_override_enable,
  input wire input_enable_override_value,
  // Pad side
  input wire pin_in,
  output wire pin_out,
  output wire pin_oe,
  output wire pullup_en,
  output wire din
);

  wire dir_eff;

  assign dir_eff = direction_override_enable ? direction_override_value
                                             : dir_bit;
  assign pin_oe = dir_eff;
  assign pin_out = port_value_override_enable ? port_value_override_value
                                              : port_bit;
  // Plain pull-up only on a GPIO input with pull-ups allowed globally
  assign pullup_en = pullup_override_enable ? pullup_override_value
                     : (port_bit & ~dir_bit & ~global_pullup_disable);
  assign din = pin_in & (input_enable_override_enable ?
                         input_enable_override_value : 1'b1);

endmodule

`default_nettype wire

// File: rtl/pefo_top.v
// Port E/F/G alternate-function override with AXI4-Lite port registers
`timescale 1ns/1ps
`default_nettype none
`include "pefo_defs.vh"

module pefo_top (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // AXI4-Lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Pads, flat vector E7..0, F7..0, G4..0
  input wire [20:0] pin_in,
  output wire [20:0] pin_out,
  output wire [20:0] pin_oe,
  output wire [20:0] pin_pullup_en,
  // Serial unit 0
  input wire serial0_rx_enable,
  input wire serial0_tx_enable,
  input wire serial0_tx_line,
  input wire serial0_sync_select,
  input wire serial0_ext_clock_out,
  output wire serial0_rx_line,
  output wire serial0_ext_clock_in,
  // Serial programming
  input wire prog_mode,
  input wire prog_data_out,
  output wire prog_data_in,
  // Timer 3 compare outputs and external interrupts 7..4
  input wire timer3_compare_c_en,
  input wire timer3_compare_c_out,
  input wire timer3_compare_b_en,
  input wire timer3_compare_b_out,
  input wire [3:0] ext_int_enable,
  output wire [3:0] ext_int_line,
  // Test access port
  input wire test_port_enable,
  input wire tap_shift_ir,
  input wire tap_shift_dr,
  input wire tap_scan_out,
  output wire tap_data_in,
  output wire tap_mode_select,
  output wire tap_test_clock,
  // Timer 0 oscillator and external memory
  input wire timer_osc_enable,
  output wire timer_osc_sel,
  input wire ext_mem_enable,
  input wire mem_addr_latch,
  input wire mem_read_strobe,
  input wire mem_write_strobe
);

  localparam E = `PEFO_E_BASE;
  localparam F = `PEFO_F_BASE;
  localparam G = `PEFO_G_BASE;
  localparam N = `PEFO_NPINS;

  // Software-visible state
  reg [1:0] ctrl_q;
  reg [7:0] port_e_q;
  reg [7:0] dir_e_q;
  reg [7:0] port_f_q;
  reg [7:0] dir_f_q;
  reg [4:0] port_g_q;
  reg [4:0] dir_g_q;
  reg [20:0] pin_sync_q;

  wire global_pullup_disable;
  wire legacy_mode;
  assign global_pullup_disable = ctrl_q[`PEFO_CTRL_NOPULL_BIT];
  assign legacy_mode = ctrl_q[`PEFO_CTRL_LEGACY_BIT];

  // Override vectors, one bit per pin
  reg [20:0] pullup_override_enable;
  reg [20:0] pullup_override_value;
  reg [20:0] direction_override_enable;
  reg [20:0] direction_override_value;
  reg [20:0] port_value_override_enable;
  reg [20:0] port_value_override_value;
  reg [20:0] input_enable_override_enable;
  reg [20:0] input_enable_override_value;

  wire [20:0] port_bits;
  wire [20:0] dir_bits;
  wire [20:0] din;
  wire jtag_shift;
  integer i;

  assign port_bits = {port_g_q, port_f_q, port_e_q};
  assign dir_bits = {dir_g_q, dir_f_q, dir_e_q};
  assign jtag_shift = tap_shift_ir | tap_shift_dr;

  always @* begin
    pullup_override_enable = {N{1'b0}};
    pullup_override_value = {N{1'b0}};
    direction_override_enable = {N{1'b0}};
    direction_override_value = {N{1'b0}};
    port_value_override_enable = {N{1'b0}};
    port_value_override_value = {N{1'b0}};
    input_enable_override_enable = {N{1'b0}};
    input_enable_override_value = {N{1'b0}};

    // Port E bit 0: receive line, also programming input
    if (serial0_rx_enable) begin
      pullup_override_enable[E+0] = 1'b1;
      pullup_override_value[E+0] =
        port_e_q[0] & ~global_pullup_disable;
      direction_override_enable[E+0] = 1'b1;
      direction_override_value[E+0] = 1'b0;
    end
    if (prog_mode) begin
      direction_override_enable[E+0] = 1'b1;
      direction_override_value[E+0] = 1'b0;
    end

    // Port E bit 1: transmit line; programming takes precedence
    if (serial0_tx_enable) begin
      pullup_override_enable[E+1] = 1'b1;
      direction_override_enable[E+1] = 1'b1;
      direction_override_value[E+1] = 1'b1;
      port_value_override_enable[E+1] = 1'b1;
      port_value_override_value[E+1] = serial0_tx_line;
    end
    if (prog_mode) begin
      pullup_override_enable[E+1] = 1'b1;
      pullup_override_value[E+1] = 1'b0;
      direction_override_enable[E+1] = 1'b1;
      direction_override_value[E+1] = 1'b1;
      port_value_override_enable[E+1] = 1'b1;
      port_value_override_value[E+1] = prog_data_out;
    end

    // Port E bit 2: direction stays with its dir bit
    port_value_override_enable[E+2] = serial0_sync_select;
    port_value_override_value[E+2] = serial0_ext_clock_out;

    // Port E bits 7..4: interrupts keep the input alive
    for (i = 0; i < 4; i = i + 1) begin
      input_enable_override_enable[E+4+i] = ext_int_enable[i];
      input_enable_override_value[E+4+i] = 1'b1;
    end
    port_value_override_enable[E+5] = timer3_compare_c_en;
    port_value_override_value[E+5] = timer3_compare_c_out;
    port_value_override_enable[E+4] = timer3_compare_b_en;
    port_value_override_value[E+4] = timer3_compare_b_out;

    // Port F: input only in legacy mode; test port wins on 7..4
    if (legacy_mode) begin
      for (i = 0; i < 8; i = i + 1) begin
        direction_override_enable[F+i] = 1'b1;
        direction_override_value[F+i] = 1'b0;
      end
    end
    if (test_port_enable) begin
      for (i = 4; i < 8; i = i + 1) begin
        pullup_override_enable[F+i] = 1'b1;
        pullup_override_value[F+i] = (i != 6);
        direction_override_enable[F+i] = 1'b1;
        direction_override_value[F+i] = 1'b0;
        input_enable_override_enable[F+i] = 1'b1;
        input_enable_override_value[F+i] = 1'b0;
      end
      direction_override_value[F+6] = jtag_shift;
      port_value_override_enable[F+6] = 1'b1;
      port_value_override_value[F+6] = tap_scan_out;
    end

    // Port G: no GPIO in legacy mode, pins parked as inputs
    if (legacy_mode) begin
      for (i = 0; i < 5; i = i + 1) begin
        pullup_override_enable[G+i] = 1'b1;
        direction_override_enable[G+i] = 1'b1;
        port_value_override_enable[G+i] = 1'b1;
        input_enable_override_enable[G+i] = 1'b1;
      end
    end
    if (timer_osc_enable) begin
      for (i = 3; i < 5; i = i + 1) begin
        pullup_override_enable[G+i] = 1'b1;
        pullup_override_value[G+i] = 1'b0;
        direction_override_enable[G+i] = 1'b1;
        direction_override_value[G+i] = 1'b0;
        input_enable_override_enable[G+i] = 1'b1;
        input_enable_override_value[G+i] = 1'b0;
      end
    end
    if (ext_mem_enable) begin
      for (i = 0; i < 3; i = i + 1) begin
        pullup_override_enable[G+i] = 1'b1;
        pullup_override_value[G+i] = 1'b0;
        direction_override_enable[G+i] = 1'b1;
        direction_override_value[G+i] = 1'b1;
        port_value_override_enable[G+i] = 1'b1;
      end
      port_value_override_value[G+2] = mem_addr_latch;
      port_value_override_value[G+1] = mem_read_strobe;
      port_value_override_value[G+0] = mem_write_strobe;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N; gi = gi + 1) begin : g_pin
      pefo_pin_cell u_cell (
        .port_bit(port_bits[gi]),
        .dir_bit(dir_bits[gi]),
        .global_pullup_disable(global_pullup_disable),
        .pullup_override_enable(pullup_override_enable[gi]),
        .pullup_override_value(pullup_override_value[gi]),
        .direction_override_enable(direction_override_enable[gi]),
        .direction_override_value(direction_override_value[gi]),
        .port_value_override_enable(port_value_override_enable[gi]),
        .port_value_override_value(port_value_override_value[gi]),
        .input_enable_override_enable(input_enable_override_enable[gi]),
        .input_enable_override_value(input_enable_override_value[gi]),
        .pin_in(pin_in[gi]),
        .pin_out(pin_out[gi]),
        .pin_oe(pin_oe[gi]),
        .pullup_en(pin_pullup_en[gi]),
        .din(din[gi])
      );
    end
  endgenerate

  // Peripheral-facing inputs, taken raw from the pads
  assign serial0_rx_line = pin_in[E+0] & serial0_rx_enable;
  assign prog_data_in = pin_in[E+0] & prog_mode;
  assign serial0_ext_clock_in = pin_in[E+2] & serial0_sync_select;
  assign ext_int_line = din[E+7:E+4];
  // Tester owns these pins and their clock; nothing is resampled here
  assign tap_data_in = pin_in[F+7] & test_port_enable;
  assign tap_mode_select = pin_in[F+5] & test_port_enable;
  assign tap_test_clock = pin_in[F+4] & test_port_enable;
  assign timer_osc_sel = timer_osc_enable;

  // Software pin view; test port pins read zero through din
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      pin_sync_q <= {N{1'b0}};
    end else begin
      pin_sync_q <= din;
    end
  end

  // AXI4-Lite slave: write taken only with address and data together
  wire wr_take;
  wire rd_take;
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_take = s_axi_awready;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take = s_axi_arvalid & s_axi_arready;

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[1:0] == 2'h0) && (addr <= `PEFO_OVRD_OFS);
    end
  endfunction

  wire wr_lo;
  assign wr_lo = wr_take & s_axi_wstrb[0];

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_q <= `PEFO_CTRL_RST;
      port_e_q <= `PEFO_PORT8_RST;
      dir_e_q <= `PEFO_PORT8_RST;
      port_f_q <= `PEFO_PORT8_RST;
      dir_f_q <= `PEFO_PORT8_RST;
      port_g_q <= `PEFO_PORT5_RST;
      dir_g_q <= `PEFO_PORT5_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PEFO_RESP_OKAY;
    end else begin
      if (wr_lo) begin
        case (s_axi_awaddr)
          `PEFO_CTRL_OFS: ctrl_q <= s_axi_wdata[1:0];
          `PEFO_PORTE_OFS: port_e_q <= s_axi_wdata[7:0];
          `PEFO_DIRE_OFS: dir_e_q <= s_axi_wdata[7:0];
          `PEFO_PORTF_OFS: port_f_q <= s_axi_wdata[7:0];
          `PEFO_DIRF_OFS: dir_f_q <= s_axi_wdata[7:0];
          `PEFO_PORTG_OFS: port_g_q <= s_axi_wdata[4:0];
          `PEFO_DIRG_OFS: dir_g_q <= s_axi_wdata[4:0];
          default: ctrl_q <= ctrl_q;
        endcase
      end
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(s_axi_awaddr) ? `PEFO_RESP_OKAY
                                            : `PEFO_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PEFO_RESP_OKAY;
    end else begin
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? `PEFO_RESP_OKAY
                                            : `PEFO_RESP_SLVERR;
        case (s_axi_araddr)
          `PEFO_CTRL_OFS: s_axi_rdata <= {30'h0, ctrl_q};
          `PEFO_PORTE_OFS: s_axi_rdata <= {24'h0, port_e_q};
          `PEFO_DIRE_OFS: s_axi_rdata <= {24'h0, dir_e_q};
          `PEFO_PINE_OFS: s_axi_rdata <= {24'h0, pin_sync_q[E+7:E]};
          `PEFO_PORTF_OFS: s_axi_rdata <= {24'h0, port_f_q};
          `PEFO_DIRF_OFS: s_axi_rdata <= {24'h0, dir_f_q};
          `PEFO_PINF_OFS: s_axi_rdata <= {24'h0, pin_sync_q[F+7:F]};
          `PEFO_PORTG_OFS: s_axi_rdata <= {27'h0, port_g_q};
          `PEFO_DIRG_OFS: s_axi_rdata <= {27'h0, dir_g_q};
          `PEFO_PING_OFS: s_axi_rdata <= {27'h0, pin_sync_q[G+4:G]};
          `PEFO_OVRD_OFS: s_axi_rdata <= {11'h0, direction_override_enable};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// File: tb/pefo_pad_model.sv
// Pad model: resolves each pin from device drive, tester drive or pull-up
`timescale 1ns/1ps
`default_nettype none
module pefo_pad_model (
  // Device and tester sides
  input wire logic clk_sys,
  input wire logic [20:0] pin_out,
  input wire logic [20:0] pin_oe,
  input wire logic [20:0] pin_pullup_en,
  input wire logic [20:0] ext_oe,
  input wire logic [20:0] ext_val,
  // Resolved pad level
  output logic [20:0] pin_in
);
  logic [20:0] float_q = 21'h0;
  // Open pads wander so a stale level never passes for a real one
  always @(posedge clk_sys) float_q <= ~float_q;
  // Tester supplies F4 clock, F5 select and F7 data here
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) |
    (~pin_oe & ~ext_oe & (pin_pullup_en | float_q));
endmodule
`default_nettype wire

// File: tb/pefo_properties.sv
// Checker for pin overrides and the write handshake of the override block
`timescale 1ns/1ps
`default_nettype none
module pefo_properties (
  // Clock, reset, write handshake
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  // Pads
  input wire logic [20:0] pin_in,
  input wire logic [20:0] pin_out,
  input wire logic [20:0] pin_oe,
  input wire logic [20:0] pin_pullup_en,
  // Peripherals
  input wire logic serial0_rx_enable,
  input wire logic serial0_tx_enable,
  input wire logic serial0_tx_line,
  input wire logic serial0_sync_select,
  input wire logic serial0_ext_clock_out,
  input wire logic serial0_rx_line,
  input wire logic prog_mode,
  input wire logic prog_data_out,
  input wire logic timer3_compare_c_en,
  input wire logic timer3_compare_c_out,
  input wire logic test_port_enable,
  input wire logic tap_shift_ir,
  input wire logic tap_shift_dr,
  input wire logic tap_scan_out,
  input wire logic ext_mem_enable,
  input wire logic mem_addr_latch,
  input wire logic mem_read_strobe,
  input wire logic mem_write_strobe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence s_wr_answer;
    s_axi_bvalid && !s_axi_awready;
  endsequence
  a_wr_resp_next: assert property (s_wr_take |=> s_wr_answer)
    else $error("write response not raised one cycle after take");
  a_e2_sync_clock: assert property (
    serial0_sync_select && pin_oe[2] |-> pin_out[2] == serial0_ext_clock_out)
    else $error("E2 clock output mismatch");
  a_prog_drive: assert property (
    prog_mode |-> pin_oe[1] && pin_out[1] == prog_data_out)
    else $error("E1 programming output mismatch");
  a_rx_force_in: assert property (
    serial0_rx_enable |-> !pin_oe[0] && serial0_rx_line == pin_in[0])
    else $error("E0 receive input mismatch");
  a_tx_force_out: assert property (
    serial0_tx_enable && !prog_mode |-> pin_oe[1] && !pin_pullup_en[1]
    && pin_out[1] == serial0_tx_line) else $error("E1 transmit mismatch");
  a_cmp_c_drive: assert property (
    timer3_compare_c_en |-> pin_out[5] == timer3_compare_c_out)
    else $error("E5 compare output mismatch");
  a_tdo_shift_only: assert property (
    test_port_enable |-> pin_oe[14] == (tap_shift_ir || tap_shift_dr)
    && pin_out[14] == tap_scan_out) else $error("F6 scan output mismatch");
  // Pull-ups must hold through reset as well, so no reset gating here
  a_tap_pins_held: assert property (disable iff (1'b0)
    test_port_enable |-> pin_pullup_en[15:12] == 4'hb && !pin_oe[15]
    && !pin_oe[13] && !pin_oe[12]) else $error("F7..4 override mismatch");
  a_mem_strobes: assert property (
    ext_mem_enable |-> pin_oe[18:16] == 3'h7 && pin_pullup_en[18:16] == 3'h0
    && pin_out[18:16] == {mem_addr_latch, mem_read_strobe, mem_write_strobe})
    else $error("G2..0 strobe mismatch");
endmodule
bind pefo_top pefo_properties u_props (.*);
`default_nettype wire

// File: tb/tb_pefo_top.sv
// Self-checking bench for the port E/F/G override block
`timescale 1ns/1ps
`default_nettype none
`include "pefo_defs.vh"
module tb_pefo_top;
  logic clk_sys = 1'h0, rst_b = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0, ext_int_enable = 4'h0, ext_int_line;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [20:0] pin_in, pin_out, pin_oe, pin_pullup_en;
  logic [20:0] ext_oe = 21'h0, ext_val = 21'h0;
  logic serial0_rx_enable = 1'h0, serial0_tx_enable = 1'h0;
  logic serial0_tx_line = 1'h0, serial0_sync_select = 1'h0;
  logic serial0_ext_clock_out = 1'h0, prog_mode = 1'h0, prog_data_out = 1'h0;
  logic timer3_compare_c_en = 1'h0, timer3_compare_c_out = 1'h0;
  logic timer3_compare_b_en = 1'h0, timer3_compare_b_out = 1'h0;
  logic test_port_enable = 1'h0, tap_shift_ir = 1'h0, tap_shift_dr = 1'h0;
  logic tap_scan_out = 1'h0, timer_osc_enable = 1'h0, ext_mem_enable = 1'h0;
  logic mem_addr_latch = 1'h0, mem_read_strobe = 1'h0, mem_write_strobe = 1'h0;
  logic serial0_rx_line, serial0_ext_clock_in, prog_data_in, tap_data_in;
  logic tap_mode_select, tap_test_clock, timer_osc_sel;
  integer mismatches = 0;
  integer check_count = 0;

  pefo_top DUT (.*);
  pefo_pad_model u_pad (.*);

  always #4 clk_sys = ~clk_sys;

  task final_report;
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count = check_count + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Every handshake wait is bounded so a stuck slave ends the run
  task automatic bump(inout integer n);
    n = n + 1;
    if (n > 100) begin
      mismatches = mismatches + 1;
      $display("Error handshake expected answer seen timeout");
      final_report;
    end
  endtask

  task tick;
    @(posedge clk_sys);
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    integer n;
    logic aw_busy, w_busy;
    n = 0;
    aw_busy = 1'h1;
    w_busy = 1'h1;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // Each channel is released on its own ready edge
    while (aw_busy | w_busy) begin
      @(posedge clk_sys);
      bump(n);
      if (aw_busy && s_axi_awready === 1'h1) begin
        aw_busy = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w_busy && s_axi_wready === 1'h1) begin
        w_busy = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (s_axi_bvalid !== 1'h1) begin
      @(posedge clk_sys);
      bump(n);
    end
    s_axi_bready <= 1'h0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    integer n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      bump(n);
    end while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) begin
      @(posedge clk_sys);
      bump(n);
    end
    s_axi_rready <= 1'h0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    test_port_enable <= 1'h1;
    #2;
    chk("pullup_f", 32'hb0, 32'(pin_pullup_en[15:8]));
    tick;
    rst_b <= 1'h1;
    axi_read(`PEFO_CTRL_OFS, 32'h0, `PEFO_RESP_OKAY);
    axi_write(8'h3c, 32'h1, `PEFO_RESP_SLVERR);
    axi_read(8'h3c, 32'h0, `PEFO_RESP_SLVERR);
    axi_write(`PEFO_PINE_OFS, 32'hff, `PEFO_RESP_OKAY);
    tick;
    ext_oe <= 21'h00b00f;
    ext_val <= 21'h00b00f;
    tap_shift_dr <= 1'h1;
    tap_scan_out <= 1'h1;
    #2;
    chk("oe_f", 32'h40, 32'(pin_oe[15:8]));
    chk("tdo", 32'h1, 32'(pin_out[14]));
    chk("tap_data_in", 32'h1, 32'(tap_data_in));
    chk("tap_mode_select", 32'h1, 32'(tap_mode_select));
    chk("tap_test_clock", 32'h1, 32'(tap_test_clock));
    tick;
    tap_shift_dr <= 1'h0;
    tap_shift_ir <= 1'h1;
    #2;
    chk("oe_f", 32'h40, 32'(pin_oe[15:8]));
    // F outputs set once and then left still
    axi_write(`PEFO_PORTF_OFS, 32'hff, `PEFO_RESP_OKAY);
    axi_write(`PEFO_DIRF_OFS, 32'hff, `PEFO_RESP_OKAY);
    tick;
    tap_shift_ir <= 1'h0;
    ext_oe <= 21'h000005;
    ext_val <= 21'h000005;
    #2;
    chk("oe_f", 32'h0f, 32'(pin_oe[15:8]));
    chk("pullup_f", 32'hb0, 32'(pin_pullup_en[15:8]));
    axi_read(`PEFO_PINF_OFS, 32'h0f, `PEFO_RESP_OKAY);
    axi_write(`PEFO_CTRL_OFS, 32'h2, `PEFO_RESP_OKAY);
    axi_write(`PEFO_PORTG_OFS, 32'h1f, `PEFO_RESP_OKAY);
    axi_write(`PEFO_DIRG_OFS, 32'h1f, `PEFO_RESP_OKAY);
    #2;
    chk("oe_f", 32'h0, 32'(pin_oe[15:8]));
    chk("oe_g", 32'h0, 32'(pin_oe[20:16]));
    axi_read(`PEFO_PING_OFS, 32'h0, `PEFO_RESP_OKAY);
    tick;
    ext_mem_enable <= 1'h1;
    mem_addr_latch <= 1'h1;
    mem_write_strobe <= 1'h1;
    timer_osc_enable <= 1'h1;
    #2;
    chk("oe_g", 32'h07, 32'(pin_oe[20:16]));
    chk("out_g", 32'h5, 32'(pin_out[18:16]));
    chk("osc", 32'h1, 32'(timer_osc_sel));
    tick;
    ext_mem_enable <= 1'h0;
    timer_osc_enable <= 1'h0;
    test_port_enable <= 1'h0;
    axi_write(`PEFO_CTRL_OFS, 32'h0, `PEFO_RESP_OKAY);
    #2;
    chk("oe_g", 32'h1f, 32'(pin_oe[20:16]));
    chk("oe_f", 32'hff, 32'(pin_oe[15:8]));
    axi_write(`PEFO_DIRE_OFS, 32'h04, `PEFO_RESP_OKAY);
    tick;
    serial0_sync_select <= 1'h1;
    serial0_ext_clock_out <= 1'h1;
    #2;
    chk("e2", 32'h3, 32'({pin_oe[2], pin_out[2]}));
    axi_write(`PEFO_DIRE_OFS, 32'h01, `PEFO_RESP_OKAY);
    axi_write(`PEFO_PORTE_OFS, 32'h03, `PEFO_RESP_OKAY);
    tick;
    serial0_rx_enable <= 1'h1;
    serial0_tx_enable <= 1'h1;
    serial0_tx_line <= 1'h1;
    #2;
    chk("e2_in", 32'h1, 32'({pin_oe[2], serial0_ext_clock_in}));
    chk("e0", 32'h1, 32'({pin_oe[0], serial0_rx_line}));
    chk("pullup_e0", 32'h1, 32'(pin_pullup_en[0]));
    chk("e1", 32'h6, 32'({pin_oe[1], pin_out[1], pin_pullup_en[1]}));
    tick;
    prog_mode <= 1'h1;
    #2;
    chk("e1", 32'h2, 32'({pin_oe[1], pin_out[1]}));
    chk("pdi", 32'h1, 32'(prog_data_in));
    axi_write(`PEFO_CTRL_OFS, 32'h1, `PEFO_RESP_OKAY);
    #2;
    chk("pullup_e0", 32'h0, 32'(pin_pullup_en[0]));
    tick;
    ext_int_enable <= 4'hf;
    ext_oe <= 21'h0000f0;
    ext_val <= 21'h0000a0;
    timer3_compare_c_en <= 1'h1;
    timer3_compare_c_out <= 1'h1;
    timer3_compare_b_en <= 1'h1;
    timer3_compare_b_out <= 1'h1;
    #2;
    chk("int_line", 32'ha, 32'(ext_int_line));
    tick;
    ext_oe <= 21'h0000c0;
    axi_write(`PEFO_DIRE_OFS, 32'h31, `PEFO_RESP_OKAY);
    #2;
    chk("cmp", 32'h3, 32'(pin_out[5:4]));
    chk("int_line", 32'hb, 32'(ext_int_line));
    final_report;
  end
endmodule
`default_nettype wire
